// ### rtl/fpso_pkg.sv
// Purpose: shared constants for the second fan pwm channel control block
// Assumes: 8-bit register port, 4-bit duty codes, 25 MHz clock
// Notes:   duty codes map linearly, code/15 of full duty
package fpso_pkg;

   // register offsets on the register port
   localparam logic [7:0] ADDR_SOURCE_SELECT   = 8'hCC;
   localparam logic [7:0] ADDR_OVERRIDE_POL    = 8'hCD;
   localparam logic [7:0] ADDR_SPINUP_SETUP    = 8'hCE;

   // reset values
   localparam logic [7:0] RST_SOURCE_SELECT    = 8'h00;
   localparam logic [7:0] RST_OVERRIDE_POL     = 8'h00;
   localparam logic [7:0] RST_SPINUP_SETUP     = 8'h00;

   // source-select fields
   localparam int         BIT_TABLE_BIND_1     = 0;
   localparam int         NUM_TABLES           = 4;
   localparam int         BIT_CPU_HOT_BIND     = 4;
   localparam int         BIT_REG_HOT_BIND     = 6;

   // override / polarity / lock fields
   localparam int         BIT_MANUAL_ENABLE    = 0;
   localparam int         BIT_POLARITY_INVERT  = 1;
   localparam int         BIT_HOT_LOCK_ENABLE  = 2;
   localparam int         BIT_HOT_LOCK_FLAG    = 3;
   localparam int         LSB_MANUAL_DUTY      = 4;

   // spin-up fields
   localparam int         LSB_SPINUP_DUTY      = 0;
   localparam int         BIT_SPINUP_DUR_MSB   = 4;
   localparam int         LSB_SPINUP_DUR_LOW   = 5;

   localparam int         DUTY_W               = 4;
   localparam logic [3:0] DUTY_ZERO            = 4'h0;
   localparam logic [3:0] DUTY_FULL            = 4'hF;
   localparam logic [3:0] DUR_DISABLED         = 4'h0;

   // timing
   localparam int         CLK_HZ               = 25_000_000;
   localparam int         MS_PER_SEC           = 1000;
   localparam int         MS_CYCLES            = CLK_HZ / MS_PER_SEC;
   localparam int         PWM_STEP_CYCLES      = 64;
   localparam int         MS_W                 = 15;

   typedef enum logic [0:0] {
      SU_IDLE = 1'b0,
      SU_RUN  = 1'b1
   } fpso_su_state_e;

   // spin-up duration in ms for each 4-bit duration code
   function automatic logic [MS_W-1:0] fpso_spinup_ms(input logic [3:0] code);
      logic [MS_W-1:0] ms;
      ms = 15'h0000;
      case (code)
         4'h1:    ms = 15'h0064;
         4'h2:    ms = 15'h00FA;
         4'h3:    ms = 15'h0190;
         4'h4:    ms = 15'h02BC;
         4'h5:    ms = 15'h03E8;
         4'h6:    ms = 15'h07D0;
         4'h7:    ms = 15'h0FA0;
         4'h8:    ms = 15'h1770;
         4'h9:    ms = 15'h1F40;
         4'hA:    ms = 15'h2710;
         4'hB:    ms = 15'h2EE0;
         4'hC:    ms = 15'h36B0;
         4'hD:    ms = 15'h3E80;
         4'hE:    ms = 15'h4650;
         4'hF:    ms = 15'h4E20;
         default: ms = 15'h0000;
      endcase
      return ms;
   endfunction

endpackage

// ### rtl/fpso_spinup_timer.sv
// Purpose: times one spin-up interval in whole milliseconds
// Assumes: start_i is a one-cycle pulse; dur_code_i stable while running
// Notes:   a fresh start restarts the interval
module fpso_spinup_timer
   import fpso_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
)(
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       start_i,
   input  wire logic [3:0] dur_code_i,
   output logic            active_o
);

   localparam int TICK_W = $clog2(MS_CYCLES_P + 1);

   fpso_su_state_e        state_q;
   logic [TICK_W-1:0]     tick_q;
   logic [MS_W-1:0]       ms_left_q;
   logic                  tick_done;

   assign tick_done = (tick_q == '0);

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_q   <= SU_IDLE;
         tick_q    <= '0;
         ms_left_q <= '0;
      end
      else if (start_i && dur_code_i != DUR_DISABLED)
      begin
         state_q   <= SU_RUN;
         tick_q    <= TICK_W'(MS_CYCLES_P - 1);
         ms_left_q <= fpso_spinup_ms(dur_code_i);
      end
      else
      begin
         case (state_q)
            SU_IDLE:
            begin
               tick_q <= '0;
            end
            SU_RUN:
            begin
               if (tick_done)
               begin
                  tick_q <= TICK_W'(MS_CYCLES_P - 1);
                  if (ms_left_q <= 15'h0001)
                     state_q <= SU_IDLE;
                  ms_left_q <= ms_left_q - 15'h0001;
               end
               else
               begin
                  tick_q <= tick_q - TICK_W'(1);
               end
            end
            default:
            begin
               state_q <= SU_IDLE;
            end
         endcase
      end
   end

   assign active_o = (state_q == SU_RUN);

endmodule // fpso_spinup_timer

// ### rtl/fpso_pwm_gen.sv
// Purpose: turns a 4-bit duty code into a pwm waveform
// Assumes: code 15 means full duty, code 0 means no duty
// Notes:   fifteen equal slots per period; output is a flop
module fpso_pwm_gen
   import fpso_pkg::*;
#(
   parameter int STEP_CYCLES_P = PWM_STEP_CYCLES
)(
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   input  wire logic [DUTY_W-1:0] duty_i,
   input  wire logic              invert_i,
   output logic                   pwm_o
);

   localparam int PRE_W = $clog2(STEP_CYCLES_P + 1);

   logic [PRE_W-1:0]  pre_q;
   logic [DUTY_W-1:0] slot_q;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pre_q  <= '0;
         slot_q <= '0;
      end
      else if (pre_q == PRE_W'(STEP_CYCLES_P - 1))
      begin
         pre_q  <= '0;
         // slots run 0..14, so code 15 never drops: a true full duty
         slot_q <= (slot_q == 4'hE) ? 4'h0 : slot_q + 4'h1;
      end
      else
      begin
         pre_q <= pre_q + PRE_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pwm_o <= 1'b0;
      else
         pwm_o <= (duty_i > slot_q) ^ invert_i;
   end

endmodule // fpso_pwm_gen

// ### rtl/fpso_top.sv
// Purpose: second fan pwm channel: source binding, override, lock, spin-up
// Assumes: register port strobes are single-cycle and synchronous to clk_i
// Notes:   read data is registered and appears one cycle after reg_rd_i
//          a held hot lock outranks spin-up, so a locked fan never runs below full
//
// How it works
// - source bits 0..3 bind the output to tables 1..4
// - source bit 4 binds the output to the cpu-hot ramp
// - source bit 6 binds the output to the regulator-hot ramp
// - with several bound sources the largest requested duty wins
// - tables request through lookup, hot inputs through ramp sources
// - override bit 0 enables the manual duty code
// - polarity 0 makes full duty high, polarity 1 makes it low
// - lock enable bit 2 lets a bound cpu-hot event set the lock
// - while the lock flag is set the output runs full duty
// - software writes zero to clear the lock, normal control resumes
// - lock flag stays writable when the configuration lock is on
// - manual duty code in bits 7:4 picks one of 16 duties
// - reading the manual field returns the duty code in use
// - during spin-up the manual field reads zero
// - spin-up duty code in bits 3:0 picks the spin-up duty
// - spin-up duty code zero disables spin-up
// - duration code: msb from bit 4, low bits from bits 7:5
// - a zero to nonzero duty change starts spin-up
// - duration code maps to 0, 100 ms .. 4 s, 6 s .. 20 s
module fpso_top
   import fpso_pkg::*;
#(
   parameter int MS_CYCLES_P   = MS_CYCLES,
   parameter int STEP_CYCLES_P = PWM_STEP_CYCLES
)(
   input  wire logic                             clk_i,
   input  wire logic                             reset_n_i,
   input  wire logic [7:0]                       reg_addr_i,
   input  wire logic [7:0]                       reg_wdata_i,
   input  wire logic                             reg_wr_i,
   input  wire logic                             reg_rd_i,
   input  wire logic                             config_lock_i,
   input  wire logic [NUM_TABLES-1:0][DUTY_W-1:0] table_duty_i,
   input  wire logic [DUTY_W-1:0]                cpu_hot_ramp_duty_i,
   input  wire logic [DUTY_W-1:0]                regulator_hot_ramp_duty_i,
   input  wire logic                             cpu_throttle_input_i,
   output logic [7:0]                            reg_rdata_o,
   output logic                                  pwm_o,
   output logic [DUTY_W-1:0]                     duty_code_o,
   output logic                                  spinup_active_o,
   output logic                                  hot_lock_flag_o
);

   // software state
   logic [7:0]        source_select_q;
   logic              manual_duty_enable_q;
   logic              output_polarity_invert_q;
   logic              hot_lock_enable_q;
   logic              hot_lock_flag_q;
   logic [DUTY_W-1:0] manual_duty_code_q;
   logic [DUTY_W-1:0] spinup_duty_code_q;
   logic [3:0]        spinup_duration_code;
   logic [7:0]        spinup_setup_q;

   // datapath
   localparam int NUM_SRC = NUM_TABLES + 3;
   logic [NUM_SRC-1:0][DUTY_W-1:0] src_code;
   logic [NUM_SRC-1:0][DUTY_W-1:0] src_req;
   logic [NUM_SRC-1:0]             src_bound;
   logic [DUTY_W-1:0] rd_duty_field;
   logic [DUTY_W-1:0] arb_d;
   logic [DUTY_W-1:0] arb_q;
   logic [DUTY_W-1:0] duty_d;
   logic [DUTY_W-1:0] duty_q;
   logic              spinup_start;
   logic              spinup_active;
   logic              lock_set;
   logic              lock_clear;
   logic              cfg_wr_ok;
   logic              wr_src;
   logic              wr_ovr;
   logic              wr_spin;

   // one decoder for the three offsets; unmapped offsets strobe nothing
   always_comb
   begin
      wr_src  = 1'b0;
      wr_ovr  = 1'b0;
      wr_spin = 1'b0;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            ADDR_SOURCE_SELECT: wr_src  = 1'b1;
            ADDR_OVERRIDE_POL:  wr_ovr  = 1'b1;
            ADDR_SPINUP_SETUP:  wr_spin = 1'b1;
            default:            wr_spin = 1'b0;
         endcase
      end
   end
   // the global configuration lock freezes every field but the lock flag
   assign cfg_wr_ok = !config_lock_i;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         source_select_q <= RST_SOURCE_SELECT;
      else if (wr_src && cfg_wr_ok)
         source_select_q <= reg_wdata_i;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         manual_duty_enable_q     <= RST_OVERRIDE_POL[BIT_MANUAL_ENABLE];
         output_polarity_invert_q <= RST_OVERRIDE_POL[BIT_POLARITY_INVERT];
         hot_lock_enable_q        <= RST_OVERRIDE_POL[BIT_HOT_LOCK_ENABLE];
         manual_duty_code_q       <= RST_OVERRIDE_POL[LSB_MANUAL_DUTY +: DUTY_W];
      end
      else if (wr_ovr && cfg_wr_ok)
      begin
         manual_duty_enable_q     <= reg_wdata_i[BIT_MANUAL_ENABLE];
         output_polarity_invert_q <= reg_wdata_i[BIT_POLARITY_INVERT];
         hot_lock_enable_q        <= reg_wdata_i[BIT_HOT_LOCK_ENABLE];
         manual_duty_code_q       <= reg_wdata_i[LSB_MANUAL_DUTY +: DUTY_W];
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         spinup_setup_q <= RST_SPINUP_SETUP;
      else if (wr_spin && cfg_wr_ok)
         spinup_setup_q <= reg_wdata_i;
   end

   assign spinup_duty_code_q   = spinup_setup_q[LSB_SPINUP_DUTY +: DUTY_W];
   assign spinup_duration_code = {spinup_setup_q[BIT_SPINUP_DUR_MSB],
                                  spinup_setup_q[LSB_SPINUP_DUR_LOW +: 3]};

   // lock flag: hardware set beats a software clear in the same cycle
   assign lock_set   = hot_lock_enable_q && source_select_q[BIT_CPU_HOT_BIND]
                       && cpu_throttle_input_i;
   assign lock_clear = wr_ovr && !reg_wdata_i[BIT_HOT_LOCK_FLAG];

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         hot_lock_flag_q <= RST_OVERRIDE_POL[BIT_HOT_LOCK_FLAG];
      else if (lock_set)
         hot_lock_flag_q <= 1'b1;
      else if (lock_clear)
         hot_lock_flag_q <= 1'b0;
   end

   // sources in order: tables 1..4, cpu-hot ramp, regulator-hot ramp, manual code
   assign src_code  = {manual_duty_code_q,
                       regulator_hot_ramp_duty_i,
                       cpu_hot_ramp_duty_i,
                       table_duty_i};
   assign src_bound = {manual_duty_enable_q,
                       source_select_q[BIT_REG_HOT_BIND],
                       source_select_q[BIT_CPU_HOT_BIND],
                       source_select_q[BIT_TABLE_BIND_1 +: NUM_TABLES]};

   // an unbound source offers zero, so it can never win the comparison
   genvar s;
   generate
      for (s = 0; s < NUM_SRC; s++)
      begin : g_source
         assign src_req[s] = src_bound[s] ? src_code[s] : DUTY_ZERO;
      end
   endgenerate

   always_comb
   begin
      arb_d = DUTY_ZERO;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (src_req[i] > arb_d)
            arb_d = src_req[i];
      end
      if (hot_lock_flag_q)
         arb_d = DUTY_FULL;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         arb_q <= DUTY_ZERO;
      else
         arb_q <= arb_d;
   end

   // spin-up only when its duty and duration are nonzero, and never under a lock
   assign spinup_start = (arb_q == DUTY_ZERO) && (arb_d != DUTY_ZERO)
                         && (spinup_duty_code_q != DUTY_ZERO)
                         && !hot_lock_flag_q;

   fpso_spinup_timer #(
      .MS_CYCLES_P (MS_CYCLES_P)
   ) u_spinup (
      .clk_i      (clk_i),
      .reset_n_i  (reset_n_i),
      .start_i    (spinup_start),
      .dur_code_i (spinup_duration_code),
      .active_o   (spinup_active)
   );

   // spin-up duty replaces arbitration for a full interval, but a held lock
   // outranks it: a running spin-up must not drop a locked fan below full
   always_comb
   begin
      if (hot_lock_flag_q)
         duty_d = DUTY_FULL;
      else if (spinup_active)
         duty_d = spinup_duty_code_q;
      else
         duty_d = arb_q;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         duty_q          <= DUTY_ZERO;
         spinup_active_o <= 1'b0;
      end
      else
      begin
         duty_q          <= duty_d;
         spinup_active_o <= spinup_active;
      end
   end

   assign duty_code_o     = duty_q;
   assign hot_lock_flag_o = hot_lock_flag_q;

   fpso_pwm_gen #(
      .STEP_CYCLES_P (STEP_CYCLES_P)
   ) u_pwm (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .duty_i    (duty_q),
      .invert_i  (output_polarity_invert_q),
      .pwm_o     (pwm_o)
   );

   // the duty field shows the code in use, not the one written, and zero in spin-up;
   // the registered flag keeps the field in step with duty_code_o
   assign rd_duty_field = spinup_active_o ? DUTY_ZERO : duty_q;

   // read port; unmapped offsets read zero
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            ADDR_SOURCE_SELECT:
            begin
               reg_rdata_o <= source_select_q;
            end
            ADDR_OVERRIDE_POL:
            begin
               reg_rdata_o[LSB_MANUAL_DUTY +: DUTY_W] <= rd_duty_field;
               reg_rdata_o[BIT_HOT_LOCK_FLAG]         <= hot_lock_flag_q;
               reg_rdata_o[BIT_HOT_LOCK_ENABLE]       <= hot_lock_enable_q;
               reg_rdata_o[BIT_POLARITY_INVERT]       <= output_polarity_invert_q;
               reg_rdata_o[BIT_MANUAL_ENABLE]         <= manual_duty_enable_q;
            end
            ADDR_SPINUP_SETUP:
            begin
               reg_rdata_o <= spinup_setup_q;
            end
            default:
            begin
               reg_rdata_o <= 8'h00;
            end
         endcase
      end
   end

endmodule // fpso_top

// ### verification/fpso_chk.sv
// Purpose: port assertions for fpso_top
// Assumes: one clock domain, async active-low reset
// Notes:   a held lock must show full duty even if spin-up is running
module fpso_chk
   import fpso_pkg::*;
#(
   parameter int MS_CYCLES_P   = MS_CYCLES,
   parameter int STEP_CYCLES_P = PWM_STEP_CYCLES
)(
   input wire logic              clk_i,
   input wire logic              reset_n_i,
   input wire logic [7:0]        reg_addr_i,
   input wire logic [7:0]        reg_wdata_i,
   input wire logic              reg_wr_i,
   input wire logic              reg_rd_i,
   input wire logic              cpu_throttle_input_i,
   input wire logic [7:0]        reg_rdata_o,
   input wire logic              pwm_o,
   input wire logic [DUTY_W-1:0] duty_code_o,
   input wire logic              spinup_active_o,
   input wire logic              hot_lock_flag_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   logic rd_cd;
   logic wr_cd;
   assign rd_cd = reg_rd_i && reg_addr_i == ADDR_OVERRIDE_POL;
   assign wr_cd = reg_wr_i && reg_addr_i == ADDR_OVERRIDE_POL;

   lock_no_cause_a: assert property (
      !hot_lock_flag_o && !cpu_throttle_input_i |=> !hot_lock_flag_o) else $error("lock set");
   lock_clear_a: assert property (
      hot_lock_flag_o && wr_cd && !reg_wdata_i[3] && !cpu_throttle_input_i
      |=> !hot_lock_flag_o) else $error("lock not cleared");
   lock_full_a: assert property (
      hot_lock_flag_o[*4] |-> duty_code_o == DUTY_FULL)
      else $error("locked below full");
   read_lock_a: assert property (
      rd_cd |=> reg_rdata_o[3] == $past(hot_lock_flag_o)) else $error("lock bit read");
   read_duty_a: assert property (
      rd_cd && !spinup_active_o |=> reg_rdata_o[7:4] == $past(duty_code_o))
      else $error("duty read");
   read_spin_a: assert property (
      rd_cd && spinup_active_o |=> reg_rdata_o[7:4] == DUTY_ZERO) else $error("spin read");
   pwm_full_a: assert property (
      (duty_code_o == DUTY_FULL && !reg_wr_i)[*4] |-> $stable(pwm_o)) else $error("full pwm");
   pwm_zero_a: assert property (
      (duty_code_o == DUTY_ZERO && !reg_wr_i)[*4] |-> $stable(pwm_o)) else $error("zero pwm");
   spin_min_a: assert property (
      $rose(spinup_active_o) |-> spinup_active_o[*8]) else $error("spin-up too short");

   cover property (hot_lock_flag_o);
   cover property ($rose(spinup_active_o));
   cover property (rd_cd && spinup_active_o);
endmodule // fpso_chk

bind fpso_top fpso_chk #(
   .MS_CYCLES_P(MS_CYCLES_P),
   .STEP_CYCLES_P(STEP_CYCLES_P)
) fpso_chk_i (
   .clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .cpu_throttle_input_i, .reg_rdata_o, .pwm_o, .duty_code_o, .spinup_active_o,
   .hot_lock_flag_o
);

// ### verification/fpso_fan_model.sv
// Purpose: fan motor stand-in that measures the drive it gets
// Assumes: WIN_P is one pwm period
// Notes:   the fan only listens, so it cannot misbehave
module fpso_fan_model #(
   parameter int WIN_P = 30
)(
   input  wire logic clk_i,
   input  wire logic pwm_i,
   output int        high_cnt_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [WIN_P-1:0] hist_q;
   always_ff @(posedge clk_i)
   begin
      hist_q <= {hist_q[WIN_P-2:0], pwm_i};
   end
   always_comb high_cnt_o = $countones(hist_q);
endmodule // fpso_fan_model

// ### verification/tb_top.sv
// Purpose: self-checking bench for fpso_top
// Assumes: short ms and pwm step parameters keep the run brief
// Notes:   read results are matched from a queue by a monitor
module tb_top
   import fpso_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MS_P = 4;
   localparam int STEP_P = 2;
   logic       clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic       config_lock_i = 1'b0, cpu_throttle_input_i = 1'b0, rd_pend = 1'b0;
   logic       pwm_o, spinup_active_o, hot_lock_flag_o;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, src, cd;
   logic [3:0] cpu_hot_ramp_duty_i = 4'h0, regulator_hot_ramp_duty_i = 4'h0, duty_code_o, e;
   logic [NUM_TABLES-1:0][DUTY_W-1:0] table_duty_i = 16'h0000;
   logic [31:0] seed = 32'h0000_7e42;
   logic [7:0] exp_q[$];
   logic [3:0] cds[3] = '{4'h0, 4'h7, 4'hF};
   logic [7:0] sus[3] = '{8'h29, 8'h19, 8'h20};
   int         cyc[3] = '{400, 24000, 0};
   int         errors = 0, total_checks = 0, hi, su_cnt = 0, n;

   fpso_top #(.MS_CYCLES_P(MS_P), .STEP_CYCLES_P(STEP_P)) fpso_top_i (
      .clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .config_lock_i,
      .table_duty_i, .cpu_hot_ramp_duty_i, .regulator_hot_ramp_duty_i, .cpu_throttle_input_i,
      .reg_rdata_o, .pwm_o, .duty_code_o, .spinup_active_o, .hot_lock_flag_o);
   fpso_fan_model #(.WIN_P(15 * STEP_P)) fpso_fan_model_i (.clk_i, .pwm_i(pwm_o),
      .high_cnt_o(hi));

   initial
   begin
      forever #20 clk_i = ~clk_i;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [3:0] mx(input logic [3:0] a, input logic [3:0] b);
      return (a > b) ? a : b;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // read data lands one edge after the strobe is taken
   always @(posedge clk_i)
   begin
      if (rd_pend)
         chk(reg_rdata_o, exp_q.pop_front());
      rd_pend <= reg_rd_i;
      if (spinup_active_o)
         su_cnt <= su_cnt + 1;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_i);
      exp_q.push_back(x);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk_i);
   endtask

   task automatic wait_su(input logic v, input int lim);
      for (int k = 0; k < lim && spinup_active_o !== v; k++)
         @(posedge clk_i);
      chk(8'(spinup_active_o), 8'(v));
   endtask

   initial
   begin
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd(ADDR_SOURCE_SELECT, RST_SOURCE_SELECT);
      rd(ADDR_OVERRIDE_POL, RST_OVERRIDE_POL);
      rd(ADDR_SPINUP_SETUP, RST_SPINUP_SETUP);
      rd(8'hCF, 8'h00);
      $display("test reset_values done");
      for (int k = 0; k < 12; k++)
      begin
         src = 8'(rnd());
         cd = 8'(rnd()) & 8'hF1;
         table_duty_i <= 16'(rnd());
         cpu_hot_ramp_duty_i <= 4'(rnd());
         regulator_hot_ramp_duty_i <= 4'(rnd());
         wr(ADDR_SOURCE_SELECT, src);
         wr(ADDR_OVERRIDE_POL, cd);
         idle(6);
         e = cd[0] ? cd[7:4] : 4'h0;
         for (int t = 0; t < NUM_TABLES; t++)
            if (src[t]) e = mx(e, table_duty_i[t]);
         if (src[4]) e = mx(e, cpu_hot_ramp_duty_i);
         if (src[6]) e = mx(e, regulator_hot_ramp_duty_i);
         rd(ADDR_OVERRIDE_POL, {e, cd[3:0]});
         rd(ADDR_SOURCE_SELECT, src);
      end
      $display("test arbitration done");
      wr(ADDR_SOURCE_SELECT, 8'h00);
      foreach (cds[j])
         for (int v = 0; v < 2; v++)
         begin
            wr(ADDR_OVERRIDE_POL, {cds[j], 2'b00, v[0], 1'b1});
            idle(40);
            n = v ? (15 - cds[j]) * STEP_P : cds[j] * STEP_P;
            chk(8'(hi), 8'(n));
         end
      $display("test polarity done");
      wr(ADDR_OVERRIDE_POL, 8'h00);
      cpu_hot_ramp_duty_i <= 4'h3;
      cpu_throttle_input_i <= 1'b1;
      wr(ADDR_SOURCE_SELECT, 8'h10);
      idle(6);
      rd(ADDR_OVERRIDE_POL, 8'h30);
      wr(ADDR_OVERRIDE_POL, 8'h04);
      idle(6);
      cpu_throttle_input_i <= 1'b0;
      config_lock_i <= 1'b1;
      rd(ADDR_OVERRIDE_POL, 8'hFC);
      chk(8'(hot_lock_flag_o), 8'h01);
      // bits 0 and 1 must stay frozen while only the flag clears
      wr(ADDR_OVERRIDE_POL, 8'h03);
      wr(ADDR_SOURCE_SELECT, 8'h00);
      idle(6);
      rd(ADDR_OVERRIDE_POL, 8'h34);
      chk(8'(hot_lock_flag_o), 8'h00);
      rd(ADDR_SOURCE_SELECT, 8'h10);
      config_lock_i <= 1'b0;
      $display("test lock done");
      table_duty_i <= 16'h0005;
      foreach (sus[j])
      begin
         wr(ADDR_SOURCE_SELECT, 8'h00);
         wr(ADDR_SPINUP_SETUP, sus[j]);
         idle(6);
         su_cnt = 0;
         wr(ADDR_SOURCE_SELECT, 8'h01);
         if (cyc[j] == 0)
         begin
            idle(20);
            chk(8'(spinup_active_o), 8'h00);
         end
         else
         begin
            wait_su(1'b1, 8);
            chk(8'(duty_code_o), 8'(sus[j][3:0]));
            rd(ADDR_OVERRIDE_POL, 8'h04);
            wait_su(1'b0, 30000);
            chk(8'(su_cnt >= cyc[j] && su_cnt <= cyc[j] + 4), 8'h01);
            idle(6);
            rd(ADDR_OVERRIDE_POL, 8'h54);
         end
      end
      $display("test spinup done");
      idle(4);
      conclude();
   end

   initial
   begin
      repeat (60000) @(posedge clk_i);
      errors++;
      conclude();
   end
endmodule // tb_top
